// ---- core/i2c_rx_cfg.svh ----
// Register offsets, field positions, reset values and timing for the
// I2C master receive / acknowledge / stop / arbitration engine.
// Assumes a word-index register port, two address bits wide.
`ifndef I2C_RX_CFG_SVH
`define I2C_RX_CFG_SVH
// ----------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------
`define REG_CTRL 2'h0
`define REG_STAT 2'h1
`define REG_BUF 2'h2
`define REG_DIV 2'h3
// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define CTL_START 0
`define CTL_RECV 1
`define CTL_ACK 2
`define CTL_STOP 3
`define CTL_ACK_DATA_VALUE 4
`define CTL_EN 5
// ----------------------------------------------------------------
// Status field positions (1..4 are write-one-to-clear)
// ----------------------------------------------------------------
`define ST_BF 0
`define ST_OVF 1
`define ST_WRITE_COLLISION_FLAG 2
`define ST_BCL 3
`define ST_IRQ 4
`define ST_S 5
`define ST_P 6
`define ST_ACKST 7
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CTRL_RST 8'h00
`define DIV_RST 8'h4f
`define CLK_NS 10
`endif

// ---- core/i2c_rx_pkg.sv ----
// Types shared by the I2C master engine.
// Assumes the constants header is included by the user of the types.
package i2c_rx_pkg;
  // One-hot engine states
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_START = 6'h02,
    S_TX = 6'h04,
    S_RX = 6'h08,
    S_ACK = 6'h10,
    S_STOP = 6'h20
  } eng_state_t;
endpackage : i2c_rx_pkg

// ---- core/i2c_rx_engine.sv ----
// I2C master engine: start, byte transmit/receive, acknowledge, stop,
// bus-free monitor and arbitration loss handling.
// Assumes SCL/SDA pins are open drain with external pull-ups, and a
// simple register port (strobes, read data one cycle after the strobe).
// Behaviour
// - Receive request is ignored unless the engine is idle.
// - Receive toggles SCL each rollover and shifts sampled SDA in.
// - After eighth fall: clear receive, load buffer, set full and irq, idle.
// - Buffer-full sets on byte load, clears when software reads buffer.
// - Overflow sets when a received byte completes while buffer-full still set.
// - Buffer write during receive, ack or stop is dropped, sets collision.
// - Ack: SCL low, drive ack bit, period, release, period, low, idle.
// - Stop: SDA low, count once sampled low, release SCL, then SDA.
// - Stop seen sets P; one period later clear stop enable, set irq.
// - Slave wake in sleep belongs to the slave logic, not here.
// - Reset disables the engine and drops any transfer.
// - S and P clear on reset or disable; stop on busy bus sets irq.
// - Released one sampled as zero while SCL high flags collision, idle.
// - Transmit collision halts, clears buffer-full, releases both lines.
// - Collision in start or ack aborts it and clears its enable.
// - After a collision a stop on the bus sets the irq flag.
// - Buffer write after collision restarts from the first data bit.
// - Start with SDA or SCL already low aborts and flags collision.
// - Start counts once SDA high; SCL low with SDA high is collision.
// - SDA low in start count asserts early, else low then SCL low.
// - Rollover is 2*(divider+1) clocks; SCL = clock/(4*(divider+1)).
//
// Implementation choices: the plain strobed port and the register addresses.
`include "i2c_rx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module i2c_rx_engine
  import i2c_rx_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  // Rollover reload: two counts per divider step
  function automatic logic [8:0] brg_reload(input logic [7:0] div);
    brg_reload = {div, 1'b1};
  endfunction : brg_reload

  // ----------------------------------------------------------------
  // Pin synchronisers and bus monitor
  // ----------------------------------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  // Two flops before use; third stage only for edge detection
  always_ff @(posedge clock) begin
    scl_m_q <= scl_i;
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= sda_i;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
  end
  wire bus_start_w = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire bus_stop_w = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ----------------------------------------------------------------
  // Registers and engine state
  // ----------------------------------------------------------------
  eng_state_t state_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q, buf_q, div_q, ctrl_q, rdata_q;
  logic [8:0] brg_q;
  logic scl_oe_q, sda_oe_q, low_q;
  logic bf_q, ovf_q, write_collision_flag_q, bcl_q, irq_q, s_q, p_q, ackst_q, lost_q;

  wire en_w = ctrl_q[`CTL_EN];
  wire idle_w = (state_q == S_IDLE);
  wire pend_w = |ctrl_q[`CTL_STOP:`CTL_START];
  wire wr_ctrl_w = reg_wr & (reg_addr == `REG_CTRL);
  wire wr_stat_w = reg_wr & (reg_addr == `REG_STAT);
  wire wr_buf_w = reg_wr & (reg_addr == `REG_BUF);
  wire rd_buf_w = reg_rd & (reg_addr == `REG_BUF);
  wire in_tx_w = (state_q == S_TX);
  wire in_rx_w = (state_q == S_RX);
  wire in_ack_w = (state_q == S_ACK);
  wire in_stop_w = (state_q == S_STOP);
  wire in_start_w = (state_q == S_START);

  // Requests taken only from idle, one at a time
  wire take_st_w = idle_w & en_w & ctrl_q[`CTL_START];
  wire take_rx_w = idle_w & en_w & ctrl_q[`CTL_RECV] & ~ctrl_q[`CTL_START];
  wire take_ack_w = idle_w & en_w & ctrl_q[`CTL_ACK] &
                    ~|ctrl_q[`CTL_RECV:`CTL_START];
  wire take_stop_w = idle_w & en_w & ctrl_q[`CTL_STOP] &
                     ~|ctrl_q[`CTL_ACK:`CTL_START];
  wire tx_go_w = wr_buf_w & idle_w & en_w & ~pend_w;
  wire write_collision_flag_set_w = wr_buf_w & ~idle_w;
  wire st_low_w = take_st_w & (~sda_s_q | ~scl_s_q);

  // Waiting for SCL high (clock stretch) or SDA low holds the count
  wire wait_w = (~scl_oe_q & ~scl_s_q & ph_q[0] &
                 (in_tx_w | in_rx_w | in_ack_w | in_stop_w)) |
                (in_stop_w & (ph_q == 2'h0) & sda_s_q) |
                (in_stop_w & (ph_q == 2'h2) & ~(sda_s_q & scl_s_q));
  wire early_w = in_start_w & (ph_q == 2'h0) & scl_s_q & ~sda_s_q;
  wire restart_w = idle_w | wait_w | early_w;
  wire tick_w = (brg_q == 9'h000) & ~restart_w;

  // ----------------------------------------------------------------
  // Engine events
  // ----------------------------------------------------------------
  wire hi_tick_w = ph_q[0] & tick_w;
  wire rx_end_w = in_rx_w & hi_tick_w & (bit_q == 4'h7);
  wire tx_end_w = in_tx_w & hi_tick_w & (bit_q == 4'h8);
  wire ack_end_w = in_ack_w & hi_tick_w;
  wire st_end_w = in_start_w & (ph_q == 2'h1) & tick_w;
  wire stop_end_w = in_stop_w & (ph_q == 2'h2) & tick_w;
  wire [7:0] rx_byte_w = {shift_q[6:0], sda_s_q};
  // Released one read back as zero while SCL high; in start, SCL low with SDA high
  wire tx_col_w = in_tx_w & ph_q[0] & (bit_q < 4'h8) & ~sda_oe_q &
                  scl_s_q & ~sda_s_q;
  wire ack_col_w = in_ack_w & ph_q[0] & ~sda_oe_q & scl_s_q &
                   ~sda_s_q;
  wire st_col_w = in_start_w & (ph_q == 2'h0) & sda_s_q &
                  ~scl_s_q;
  wire coll_w = tx_col_w | ack_col_w | st_col_w | st_low_w;
  wire done_w = rx_end_w | tx_end_w | ack_end_w | st_end_w | stop_end_w;

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  // Reload at zero gives a rollover every 2*(div+1) clocks
  always_ff @(posedge clock) begin
    if (sys_rst || restart_w || brg_q == 9'h000) begin
      brg_q <= brg_reload(div_q);
    end else begin
      brg_q <= brg_q - 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Engine sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || !en_w || coll_w) begin
      // Abort leaves both lines released
      state_q <= S_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      if (sys_rst) shift_q <= 8'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          ph_q <= 2'h0;
          bit_q <= 4'h0;
          if (take_st_w) begin
            state_q <= S_START;
          end else if (take_rx_w) begin
            state_q <= S_RX;
            scl_oe_q <= 1'b1;
            sda_oe_q <= 1'b0;
          end else if (take_ack_w) begin
            state_q <= S_ACK;
            scl_oe_q <= 1'b1;
            sda_oe_q <= ~ctrl_q[`CTL_ACK_DATA_VALUE];
          end else if (take_stop_w) begin
            state_q <= S_STOP;
            scl_oe_q <= 1'b1;
            sda_oe_q <= 1'b1;
          end else if (tx_go_w) begin
            state_q <= S_TX;
            shift_q <= reg_wdata;
            scl_oe_q <= 1'b1;
            sda_oe_q <= ~reg_wdata[7];
          end
        end
        S_START: begin
          // Early assert when another master already pulled SDA
          if (early_w || (ph_q == 2'h0 && tick_w)) begin
            sda_oe_q <= 1'b1;
            ph_q <= 2'h1;
          end else if (st_end_w) begin
            scl_oe_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_TX: begin
          if (!ph_q[0] && tick_w) begin
            scl_oe_q <= 1'b0;
            ph_q <= 2'h1;
          end else if (hi_tick_w) begin
            scl_oe_q <= 1'b1;
            ph_q <= 2'h0;
            bit_q <= bit_q + 4'h1;
            shift_q <= {shift_q[6:0], 1'b0};
            // Release SDA for the acknowledge slot
            sda_oe_q <= (bit_q < 4'h7) ? ~shift_q[6] : 1'b0;
            if (tx_end_w) state_q <= S_IDLE;
          end
        end
        S_RX: begin
          if (!ph_q[0] && tick_w) begin
            scl_oe_q <= 1'b0;
            ph_q <= 2'h1;
          end else if (hi_tick_w) begin
            scl_oe_q <= 1'b1;
            shift_q <= rx_byte_w;
            ph_q <= 2'h0;
            bit_q <= bit_q + 4'h1;
            if (rx_end_w) state_q <= S_IDLE;
          end
        end
        S_ACK: begin
          if (!ph_q[0] && tick_w) begin
            scl_oe_q <= 1'b0;
            ph_q <= 2'h1;
          end else if (ack_end_w) begin
            scl_oe_q <= 1'b1;
            sda_oe_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_STOP: begin
          if (ph_q == 2'h0 && tick_w) begin
            scl_oe_q <= 1'b0;
            ph_q <= 2'h1;
          end else if (hi_tick_w) begin
            sda_oe_q <= 1'b0;
            ph_q <= 2'h2;
          end else if (stop_end_w) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control and data registers
  // ----------------------------------------------------------------
  // Enables accepted only when idle with nothing pending; the
  // engine clears all four on completion, collision or disable
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q <= `CTRL_RST;
      div_q <= `DIV_RST;
      buf_q <= 8'h00;
    end else begin
      if (wr_ctrl_w) begin
        ctrl_q[7:`CTL_ACK_DATA_VALUE] <= reg_wdata[7:`CTL_ACK_DATA_VALUE];
        if (idle_w && !pend_w) begin
          ctrl_q[`CTL_STOP:`CTL_START] <=
            reg_wdata[`CTL_STOP:`CTL_START];
        end
      end
      if (done_w || coll_w || !en_w) begin
        ctrl_q[`CTL_STOP:`CTL_START] <= 4'h0;
      end
      if (reg_wr && reg_addr == `REG_DIV) div_q <= reg_wdata;
      if (rx_end_w) begin
        buf_q <= rx_byte_w;
      end else if (tx_go_w) begin
        buf_q <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags: hardware set wins over software clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      {bf_q, ovf_q, write_collision_flag_q, bcl_q, irq_q} <= 5'h00;
      {s_q, p_q, ackst_q, lost_q} <= 4'h0;
    end else begin
      // Buffer full: set on load, cleared by read or when a transmit ends or is lost
      bf_q <= rx_end_w | tx_go_w |
              (bf_q & ~rd_buf_w & ~tx_col_w & ~tx_end_w);
      ovf_q <= (rx_end_w & bf_q) |
               (ovf_q & ~(wr_stat_w & reg_wdata[`ST_OVF]));
      write_collision_flag_q <= write_collision_flag_set_w |
                (write_collision_flag_q & ~(wr_stat_w & reg_wdata[`ST_WRITE_COLLISION_FLAG]));
      bcl_q <= coll_w |
               (bcl_q & ~(wr_stat_w & reg_wdata[`ST_BCL]));
      // Stop seen on a busy bus or after a lost arbitration
      irq_q <= done_w | (bus_stop_w & (s_q | lost_q)) |
               (irq_q & ~(wr_stat_w & reg_wdata[`ST_IRQ]));
      lost_q <= coll_w | (lost_q & ~bus_stop_w);
      if (tx_end_w) ackst_q <= sda_s_q;
      // Start/stop seen bits cleared while disabled
      s_q <= en_w & (bus_start_w | (s_q & ~bus_stop_w));
      p_q <= en_w & (bus_stop_w | (p_q & ~bus_start_w));
    end
  end

  // ----------------------------------------------------------------
  // Register read port and pin outputs
  // ----------------------------------------------------------------
  wire [7:0] stat_w = {ackst_q, p_q, s_q, irq_q, bcl_q, write_collision_flag_q, ovf_q, bf_q};
  wire [7:0] rmux_w = (reg_addr == `REG_CTRL) ? ctrl_q :
                      (reg_addr == `REG_STAT) ? stat_w :
                      (reg_addr == `REG_BUF) ? buf_q : div_q;
  // Read data only valid in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
      low_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd ? rmux_w : 8'h00;
      low_q <= 1'b0;
    end
  end
  assign reg_rdata = rdata_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign scl_o = low_q;
  assign sda_o = low_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_rx_ignored: assert property (
    (wr_ctrl_w && reg_wdata[`CTL_RECV] && !idle_w && !ctrl_q[`CTL_RECV])
    |=> !ctrl_q[`CTL_RECV]) else $error("receive request taken while busy");
  a_rx_complete: assert property (
    rx_end_w |=> bf_q && idle_w && !ctrl_q[`CTL_RECV] && irq_q &&
    buf_q == $past(rx_byte_w) && scl_oe_q)
    else $error("receive completion wrong");
  a_bf_read: assert property (
    (rd_buf_w && !rx_end_w && !tx_go_w) |=> !bf_q)
    else $error("buffer full not cleared by read");
  a_ovf_set: assert property (
    (rx_end_w && bf_q) |=> ovf_q) else $error("overflow missed");
  a_write_collision_flag_drop: assert property (
    write_collision_flag_set_w && !rx_end_w |=> write_collision_flag_q && $stable(buf_q))
    else $error("busy buffer write not dropped");
  a_ack_drive: assert property (
    take_ack_w && !coll_w |=> in_ack_w && scl_oe_q &&
    sda_oe_q == !ctrl_q[`CTL_ACK_DATA_VALUE]) else $error("ack drive wrong");
  a_stop_sda: assert property (
    take_stop_w && !coll_w |=> (sda_oe_q && scl_oe_q) [*2])
    else $error("stop does not pull SDA low");
  a_coll_release: assert property (
    coll_w |=> !scl_oe_q && !sda_oe_q && bcl_q && idle_w)
    else $error("collision does not release the bus");
  a_start_abort: assert property (
    st_low_w |=> idle_w && bcl_q && !ctrl_q[`CTL_START])
    else $error("start on low bus not aborted");

  c_rx_byte: cover property (rx_end_w);
  c_stop_done: cover property (stop_end_w);
  c_tx_lost: cover property (tx_col_w);
  c_ack_done: cover property (ack_end_w);
  c_start_early: cover property (early_w);

endmodule : i2c_rx_engine

`default_nettype wire

// ---- dv/i2c_far_side.sv ----
// Far-side I2C party: a slave that shifts a byte out on SDA, may stretch
// SCL, can jam SDA low like a rival master, and logs bits at SCL rises.
// Assumes the bench resolves the open-drain wires with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module i2c_far_side (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic arm,
  input wire logic jam_sda,
  input wire logic [7:0] tx_byte,
  input wire logic [7:0] stretch,
  output logic scl_low,
  output logic sda_low,
  output logic [8:0] sh9
);
  logic scl_q;
  logic [3:0] idx_q;
  logic [7:0] hold_q;
  wire scl_fall = scl_q & ~scl;
  wire scl_rise = ~scl_q & scl;
  // Bit index, stretch timer and bit log; data moves only after a fall
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      idx_q <= 4'h0;
      hold_q <= 8'h00;
      sh9 <= 9'h000;
    end else begin
      scl_q <= scl;
      if (!arm) begin
        idx_q <= 4'h0;
      end else if (scl_fall && idx_q < 4'h8) begin
        idx_q <= idx_q + 4'h1;
      end
      if (scl_fall && arm) begin
        hold_q <= stretch;
      end else if (hold_q != 8'h00) begin
        hold_q <= hold_q - 8'h01;
      end
      if (scl_rise) begin
        sh9 <= {sh9[7:0], sda};
      end
    end
  end
  // Released after the eighth bit so the pull-up takes the line high
  assign scl_low = hold_q != 8'h00;
  assign sda_low = jam_sda |
    (arm & (idx_q < 4'h8) & ~tx_byte[3'h7 - idx_q[2:0]]);
endmodule : i2c_far_side
`default_nettype wire

// ---- dv/i2c_master_rx_ack_stop_arbitration_bench.sv ----
// Self-checking bench for the I2C master engine: register tasks, then
// receive, acknowledge, stop and collision sequences against a far side.
// Assumes pull-ups on both bus lines, resolved here from all enables.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_rx_cfg.svh"
module i2c_master_rx_ack_stop_arbitration_bench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic arm = 1'b0;
  logic jam_sda = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] stretch = 8'h00;
  logic [7:0] reg_rdata, d;
  logic scl_o, scl_oe, sda_o, sda_oe, m_scl_low, m_sda_low;
  logic [8:0] sh9;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_stop = 0;
  int n_start = 0;
  int ns0, nt0;
  wire scl = (scl_oe ? scl_o : 1'b1) & ~m_scl_low;
  wire sda = (sda_oe ? sda_o : 1'b1) & ~m_sda_low;

  initial forever #5 clock = ~clock;

  i2c_rx_engine DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  i2c_far_side far (.clock(clock), .sys_rst(sys_rst), .scl(scl), .sda(sda),
    .arm(arm), .jam_sda(jam_sda), .tx_byte(tx_byte), .stretch(stretch),
    .scl_low(m_scl_low), .sda_low(m_sda_low), .sh9(sh9));

  // Bus condition watcher: SDA edges while SCL is high
  always @(posedge sda) if (scl === 1'b1) n_stop++;
  always @(negedge sda) if (scl === 1'b1) n_start++;

  // Hang guard, well above the roughly 1200 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Register port tasks and compares
  // ----------------------------------------------------------------
  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // Bounded poll; the last read is always compared
  task automatic poll(input logic [1:0] a, input logic [7:0] m,
                      input logic [7:0] e, input int tries);
    logic [7:0] v;
    for (int i = 0; i < tries; i++) begin
      rd(a, v);
      if ((v & m) === e) break;
    end
    chk8(v & m, e);
  endtask : poll
  // One byte from the far side; optional buffer write while it runs
  task automatic rx(input logic [7:0] b, input logic [7:0] s,
                    input logic bump);
    tx_byte <= b;
    stretch <= s;
    wr(`REG_CTRL, 8'h22);
    repeat (3) @(posedge clock);
    arm <= 1'b1;
    if (bump) wr(`REG_BUF, 8'hff);
    poll(`REG_CTRL, 8'h02, 8'h00, 600);
    arm <= 1'b0;
  endtask : rx
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    poll(`REG_CTRL, 8'hff, `CTRL_RST, 1);
    poll(`REG_STAT, 8'hff, 8'h00, 1);
    poll(`REG_DIV, 8'hff, `DIV_RST, 1);
    wr(`REG_DIV, 8'h03);
    wr(`REG_CTRL, 8'h20);
    // Receive with a buffer write dropped in mid-byte
    rx(8'ha5, 8'h00, 1'b1);
    poll(`REG_STAT, 8'hff, 8'h15, 1);
    chk1(scl_oe, 1'b1);
    poll(`REG_BUF, 8'hff, 8'ha5, 1);
    poll(`REG_STAT, 8'h01, 8'h00, 1);
    wr(`REG_STAT, 8'h1e);
    // Slow far side, then two bytes with the buffer left unread
    rx(8'h3c, 8'h14, 1'b0);
    poll(`REG_BUF, 8'hff, 8'h3c, 1);
    rx(8'h81, 8'h00, 1'b0);
    rx(8'h42, 8'h00, 1'b0);
    poll(`REG_STAT, 8'h13, 8'h13, 1);
    rd(`REG_BUF, d);
    wr(`REG_STAT, 8'h1e);
    // Acknowledge then not-acknowledge; refused requests meanwhile
    for (int k = 0; k < 2; k++) begin
      wr(`REG_CTRL, {3'b001, k[0], 4'h4});
      wr(`REG_BUF, 8'hee);
      wr(`REG_CTRL, {3'b001, k[0], 4'h2});
      poll(`REG_CTRL, 8'h02, 8'h00, 1);
      poll(`REG_CTRL, 8'hff, {3'b001, k[0], 4'h0}, 400);
      chk1(sh9[0], k[0]);
      chk1(scl_oe, 1'b1);
      poll(`REG_STAT, 8'h04, 8'h04, 1);
      wr(`REG_STAT, 8'h1e);
    end
    // Stop: exactly one stop and no start on the wires
    ns0 = n_stop;
    nt0 = n_start;
    wr(`REG_CTRL, 8'h28);
    poll(`REG_CTRL, 8'h08, 8'h00, 400);
    poll(`REG_STAT, 8'h50, 8'h50, 1);
    chk1(scl_oe | sda_oe, 1'b0);
    chk8(8'(n_stop - ns0), 8'h01);
    chk8(8'(n_start - nt0), 8'h00);
    // Start refused by a low SDA, then a rival's stop frees the bus
    wr(`REG_STAT, 8'h1e);
    jam_sda <= 1'b1;
    repeat (4) @(posedge clock);
    wr(`REG_CTRL, 8'h21);
    poll(`REG_STAT, 8'h08, 8'h08, 50);
    poll(`REG_CTRL, 8'hff, 8'h20, 1);
    chk1(scl_oe | sda_oe, 1'b0);
    wr(`REG_STAT, 8'h1e);
    jam_sda <= 1'b0;
    poll(`REG_STAT, 8'h50, 8'h50, 20);
    // Arbitration lost on a released one during transmit
    wr(`REG_STAT, 8'h1e);
    wr(`REG_CTRL, 8'h21);
    // Rival pulls SDA in the start count: assert early, no collision
    jam_sda <= 1'b1;
    poll(`REG_CTRL, 8'h01, 8'h00, 100);
    poll(`REG_STAT, 8'h08, 8'h00, 1);
    chk1(scl_oe & sda_oe, 1'b1);
    jam_sda <= 1'b0;
    wr(`REG_BUF, 8'hff);
    jam_sda <= 1'b1;
    poll(`REG_STAT, 8'h08, 8'h08, 100);
    poll(`REG_STAT, 8'h01, 8'h00, 1);
    chk1(scl_oe | sda_oe, 1'b0);
    jam_sda <= 1'b0;
    repeat (6) @(posedge clock);
    wr(`REG_STAT, 8'h1e);
    wr(`REG_BUF, 8'h5a);
    poll(`REG_STAT, 8'h14, 8'h10, 400);
    chk8(sh9[8:1], 8'h5a);
    // Reset in mid-receive abandons the byte
    tx_byte <= 8'h00;
    wr(`REG_CTRL, 8'h22);
    repeat (30) @(posedge clock);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1 chk1(scl_oe | sda_oe, 1'b0);
    poll(`REG_CTRL, 8'hff, `CTRL_RST, 1);
    poll(`REG_STAT, 8'hff, 8'h00, 1);
    poll(`REG_DIV, 8'hff, `DIV_RST, 1);
    close_out();
  end
endmodule : i2c_master_rx_ack_stop_arbitration_bench
`default_nettype wire
